// ---- rtl/fgp_defs.svh ----
/*
 * Fuel gauge parameter bank: register offsets, field positions, reset
 * values and limits as macros.
 * Assumes: included by bare name from the package and modules.
 */
`ifndef FGP_DEFS_SVH
`define FGP_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define FGP_OFS_RES_10C       8'h1A
`define FGP_OFS_RES_20C       8'h1B
`define FGP_OFS_RES_30C       8'h1C
`define FGP_OFS_RES_40C       8'h1D
`define FGP_OFS_RES_60C       8'h1E
`define FGP_OFS_RES_COEFF     8'h1F
`define FGP_OFS_TEMP_CTRL     8'h20
`define FGP_OFS_CHARGE_LEVEL  8'h21
`define FGP_OFS_VOLT_HIGH     8'h22
`define FGP_OFS_VOLT_LOW      8'h23
`define FGP_OFS_CHARGE_RESET  8'h25

// ****************************************************************
// field positions
// ****************************************************************
`define FGP_RATIO_MSB         5
`define FGP_RATIO_LSB         4
`define FGP_CHGC_MSB          3
`define FGP_CHGC_LSB          0
`define FGP_TSRC_BIT          6
`define FGP_TVAL_MSB          5
`define FGP_TVAL_LSB          0
`define FGP_LEVEL_MSB         6
`define FGP_VHI_MSB           12
`define FGP_VHI_LSB           5
`define FGP_VLO_MSB           4
`define FGP_VLO_POS           3
`define FGP_CLR_BIT           7

// ****************************************************************
// reset values and limits
// ****************************************************************
`define FGP_RES_RST           8'h3F
`define FGP_RATIO_RST         2'h0
`define FGP_CHGC_RST          4'h8
`define FGP_TSRC_RST          1'h0
`define FGP_TVAL_RST          6'h1B
`define FGP_LEVEL_MAX         7'h64
`define FGP_NUM_RES           5
`define FGP_RES_LSB_MOHM      32

`endif

// ---- rtl/fgp_pkg.sv ----
/*
 * Fuel gauge parameter bank: shared types.
 * Assumes: fgp_defs.svh is on the include path.
 */
`default_nettype none
`include "fgp_defs.svh"

package fgp_pkg;

	// one 8-bit resistance code, 32 mohm per step
	typedef logic [7:0] fgp_res_t;

	// five temperature points, index 0 is 10 degC
	typedef fgp_res_t [`FGP_NUM_RES-1:0] fgp_res_arr_t;

	// low-charge ratio encodings
	typedef enum logic [1:0] {
		FGP_RATIO_X1,
		FGP_RATIO_X2,
		FGP_RATIO_X4,
		FGP_RATIO_X8
	} fgp_ratio_t;

	typedef logic [5:0]  fgp_temp_t;
	typedef logic [6:0]  fgp_level_t;
	typedef logic [12:0] fgp_volt_t;

endpackage : fgp_pkg

`default_nettype wire

// ---- rtl/fgp_meas_if.sv ----
/*
 * Interface between the register bank and the measurement holder.
 * Assumes: one clock; all signals are synchronous to it.
 */
`timescale 1ns/10ps
`default_nettype none

interface fgp_meas_if;
	import fgp_pkg::*;

	logic       upd;     // new measurement strobe
	logic       clear;   // host clear strobe
	fgp_level_t lvl_in;
	fgp_volt_t  volt_in;
	fgp_level_t lvl;
	fgp_volt_t  volt;

	modport bank (output upd, clear, lvl_in, volt_in, input lvl, volt);
	modport hold (input upd, clear, lvl_in, volt_in, output lvl, volt);
endinterface : fgp_meas_if

`default_nettype wire

// ---- rtl/fgp_meas_hold.sv ----
/*
 * Holds the charge level and the 13-bit voltage result as one unit.
 * Assumes: gauge core strobes upd with valid data; same clock as bank.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fgp_defs.svh"

module fgp_meas_hold (
	// clock and reset
	input  wire logic    clock,
	input  wire logic    nrst,
	// link to the bank
	fgp_meas_if.hold     mif
);
	import fgp_pkg::*;

	typedef struct packed {
		fgp_level_t lvl;
		fgp_volt_t  volt;
	} fgp_hold_st_t;

	fgp_hold_st_t st_ff;
	fgp_hold_st_t nxt_st;

	// ****************************************************************
	// update / clear
	// ****************************************************************
	// a measurement in the clear cycle wins so no result is lost
	always_comb begin
		nxt_st = st_ff;
		if (mif.clear) begin
			nxt_st = '0;
		end
		if (mif.upd) begin
			// both voltage halves move in one edge
			nxt_st.volt = mif.volt_in;
			if (mif.lvl_in > `FGP_LEVEL_MAX) begin
				nxt_st.lvl = `FGP_LEVEL_MAX;
			end else begin
				nxt_st.lvl = mif.lvl_in;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign mif.lvl  = st_ff.lvl;
	assign mif.volt = st_ff.volt;

endmodule : fgp_meas_hold

`default_nettype wire

// ---- rtl/fgp_regs.sv ----
/*
 * Fuel gauge parameter register bank, reached through the register
 * port of the serial host interface engine.
 * Assumes: the engine and the gauge core run on the same clock; the
 * engine gives one-cycle read and write strobes with an 8-bit address.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fgp_defs.svh"

module fgp_regs (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               nrst,
	// register port from the host interface engine
	input  wire logic [7:0]         reg_addr,
	input  wire logic               reg_wr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_rd,
	output var  logic [7:0]         reg_rdata,
	output var  logic               reg_rvalid,
	// results from the gauge core
	input  wire logic               meas_upd,
	input  wire fgp_pkg::fgp_level_t meas_level,
	input  wire fgp_pkg::fgp_volt_t meas_volt,
	// temperature from the thermistor converter
	input  wire fgp_pkg::fgp_temp_t thermistor_input,
	// parameters to the gauge core
	output var  fgp_pkg::fgp_res_arr_t resistance_points,
	output var  fgp_pkg::fgp_ratio_t low_charge_resistance_ratio,
	output var  logic [3:0]         charging_resistance_coeff,
	output var  logic               temperature_source_select,
	output var  fgp_pkg::fgp_temp_t host_temperature_value,
	output var  fgp_pkg::fgp_temp_t battery_temperature
);
	import fgp_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		fgp_res_arr_t res;
		fgp_ratio_t   ratio;
		logic [3:0]   chg_coeff;
		logic         temp_src;
		fgp_temp_t    temp_val;
		fgp_temp_t    eff_temp;
		logic [7:0]   rdata;
		logic         rvalid;
		logic         clr;
		logic [4:0]   vlo_shadow;
		logic         shadow_ok;
	} fgp_bank_st_t;

	fgp_bank_st_t st_ff;
	fgp_bank_st_t nxt_st;

	fgp_meas_if   mif ();

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// true when the address hits one of the five resistance points
	function automatic logic fgp_is_res(input logic [7:0] a);
		fgp_is_res = (a >= `FGP_OFS_RES_10C) && (a <= `FGP_OFS_RES_60C);
	endfunction : fgp_is_res

	// point index 0..4 from a resistance address
	function automatic logic [2:0] fgp_res_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - `FGP_OFS_RES_10C;
		fgp_res_idx = d[2:0];
	endfunction : fgp_res_idx

	// low byte layout: measurement bits in 7:3, zeros below
	function automatic logic [7:0] fgp_lo_byte(input logic [4:0] v);
		fgp_lo_byte = {v, 3'h0};
	endfunction : fgp_lo_byte

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.rvalid = 1'b0;
		nxt_st.clr    = 1'b0;

		// host writes; read-only and unmapped offsets drop the data
		if (reg_wr) begin
			if (fgp_is_res(reg_addr)) begin
				nxt_st.res[fgp_res_idx(reg_addr)] = reg_wdata;
			end
			case (reg_addr)
				`FGP_OFS_RES_COEFF: begin
					// bits 7:6 unused, not stored
					nxt_st.ratio = fgp_ratio_t'(
						reg_wdata[`FGP_RATIO_MSB:`FGP_RATIO_LSB]);
					nxt_st.chg_coeff =
						reg_wdata[`FGP_CHGC_MSB:`FGP_CHGC_LSB];
				end
				`FGP_OFS_TEMP_CTRL: begin
					nxt_st.temp_src = reg_wdata[`FGP_TSRC_BIT];
					nxt_st.temp_val =
						reg_wdata[`FGP_TVAL_MSB:`FGP_TVAL_LSB];
				end
				`FGP_OFS_CHARGE_RESET: begin
					// one-cycle clear towards the result holder
					nxt_st.clr = reg_wdata[`FGP_CLR_BIT];
				end
				default: begin
					// results at 0x21..0x23 are not writable
				end
			endcase
		end

		// a clear drops any pending snapshot; a high read in the same
		// cycle still takes its snapshot, so the set wins over the clear
		if (st_ff.clr) begin
			nxt_st.vlo_shadow = 5'h00;
			nxt_st.shadow_ok  = 1'b0;
		end

		// host reads; answer registered, one cycle after the strobe
		if (reg_rd) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = 8'h00;
			if (fgp_is_res(reg_addr)) begin
				nxt_st.rdata = st_ff.res[fgp_res_idx(reg_addr)];
			end
			case (reg_addr)
				`FGP_OFS_RES_COEFF: begin
					nxt_st.rdata = {2'h0, st_ff.ratio, st_ff.chg_coeff};
				end
				`FGP_OFS_TEMP_CTRL: begin
					nxt_st.rdata = {1'b0, st_ff.temp_src, st_ff.temp_val};
				end
				`FGP_OFS_CHARGE_LEVEL: begin
					nxt_st.rdata = {1'b0, mif.lvl};
				end
				`FGP_OFS_VOLT_HIGH: begin
					// snapshot the low half so a following low read
					// matches this high byte even if a result lands
					nxt_st.rdata =
						mif.volt[`FGP_VHI_MSB:`FGP_VHI_LSB];
					nxt_st.vlo_shadow = mif.volt[`FGP_VLO_MSB:0];
					nxt_st.shadow_ok  = 1'b1;
				end
				`FGP_OFS_VOLT_LOW: begin
					if (st_ff.shadow_ok) begin
						nxt_st.rdata = fgp_lo_byte(st_ff.vlo_shadow);
					end else begin
						nxt_st.rdata =
							fgp_lo_byte(mif.volt[`FGP_VLO_MSB:0]);
					end
					nxt_st.shadow_ok = 1'b0;
				end
				default: begin
					// clear register and unmapped offsets read zero
				end
			endcase
		end

		// temperature handed to the core, picked by the source bit
		if (st_ff.temp_src) begin
			nxt_st.eff_temp = st_ff.temp_val;
		end else begin
			nxt_st.eff_temp = thermistor_input;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// results hold no documented reset; the holder zeroes them anyway
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff            <= '0;
			st_ff.res        <= {`FGP_NUM_RES{`FGP_RES_RST}};
			st_ff.ratio      <= fgp_ratio_t'(`FGP_RATIO_RST);
			st_ff.chg_coeff  <= `FGP_CHGC_RST;
			st_ff.temp_src   <= `FGP_TSRC_RST;
			st_ff.temp_val   <= `FGP_TVAL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// result holder
	// ****************************************************************
	// gauge core data goes straight in; the holder clamps the level
	assign mif.upd     = meas_upd;
	assign mif.clear   = st_ff.clr;
	assign mif.lvl_in  = meas_level;
	assign mif.volt_in = meas_volt;

	fgp_meas_hold u_hold (
		.clock (clock),
		.nrst  (nrst),
		.mif   (mif.hold)
	);

	// ****************************************************************
	// outputs, all from flip-flops
	// ****************************************************************
	assign reg_rdata                   = st_ff.rdata;
	assign reg_rvalid                  = st_ff.rvalid;
	assign resistance_points           = st_ff.res;
	assign low_charge_resistance_ratio = st_ff.ratio;
	assign charging_resistance_coeff   = st_ff.chg_coeff;
	assign temperature_source_select   = st_ff.temp_src;
	assign host_temperature_value      = st_ff.temp_val;
	assign battery_temperature         = st_ff.eff_temp;

endmodule : fgp_regs

`default_nettype wire

// ---- dv/fgp_host_model.sv ----
/*
 * Host side model: issues register reads and writes on the strobe port.
 * Assumes: called from the bench; one clock shared with the bank.
 */
`timescale 1ns/10ps
`default_nettype none

module fgp_host_model (
	// clock
	input	wire logic		clock,
	// register port towards the bank
	output	var logic [7:0]	reg_addr,
	output	var logic		reg_wr,
	output	var logic [7:0]	reg_wdata,
	output	var logic		reg_rd,
	input	wire logic [7:0]	reg_rdata,
	input	wire logic		reg_rvalid
);
	// ****************************************************************
	// bus cycles
	// ****************************************************************
	// idle lines carry flipped copies so stale values never look valid
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one write strobe; callers keep field codes in range
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr

	// one read strobe, answer awaited for a few cycles at most
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
			output logic ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		for (n = 0; n < 4 && !ok; n++) begin
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end else begin
				@(posedge clock);
				#1;
			end
		end
	endtask : rd
endmodule : fgp_host_model

`default_nettype wire

// ---- dv/fgp_regs_sva.sv ----
/*
 * Checker for the fuel gauge parameter bank, watching its ports only.
 * Assumes: bound to fgp_regs; one clock, nrst async active low.
 */
`timescale 1ns/10ps
`default_nettype none

module fgp_regs_sva (
	// clock and reset
	input	wire logic		clock,
	input	wire logic		nrst,
	// register port
	input	wire logic [7:0]	reg_addr,
	input	wire logic		reg_wr,
	input	wire logic [7:0]	reg_wdata,
	input	wire logic		reg_rd,
	input	wire logic [7:0]	reg_rdata,
	input	wire logic		reg_rvalid,
	// gauge side
	input	wire logic		meas_upd,
	input	wire fgp_pkg::fgp_level_t	meas_level,
	input	wire fgp_pkg::fgp_volt_t	meas_volt,
	input	wire fgp_pkg::fgp_temp_t	thermistor_input,
	input	wire fgp_pkg::fgp_res_arr_t	resistance_points,
	input	wire fgp_pkg::fgp_ratio_t	low_charge_resistance_ratio,
	input	wire logic [3:0]	charging_resistance_coeff,
	input	wire logic		temperature_source_select,
	input	wire fgp_pkg::fgp_temp_t	host_temperature_value,
	input	wire fgp_pkg::fgp_temp_t	battery_temperature
);
	import fgp_pkg::*;
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	// read answers come exactly one cycle later
	read_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe not answered");
	no_spurious_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without a read");
	first_point_a: assert property (
		reg_wr && reg_addr == 8'h1A |=> resistance_points[0] == $past(reg_wdata))
		else $error("10 degC point not written");
	last_point_a: assert property (
		reg_wr && reg_addr == 8'h1E |=> resistance_points[4] == $past(reg_wdata))
		else $error("60 degC point not written");
	coeff_stable_a: assert property (
		!(reg_wr && reg_addr == 8'h1F) |=> $stable(charging_resistance_coeff))
		else $error("charging coefficient moved without a write");
	temp_pick_a: assert property ($past(nrst) |->
		battery_temperature == ($past(temperature_source_select) ?
		$past(host_temperature_value) : $past(thermistor_input)))
		else $error("wrong temperature source");
	coeff_unused_a: assert property (
		reg_rvalid && $past(reg_addr) == 8'h1F |-> reg_rdata[7:6] == 2'h0)
		else $error("coefficient unused bits set");
	level_limit_a: assert property (
		reg_rvalid && $past(reg_addr) == 8'h21 |-> reg_rdata <= 8'h64)
		else $error("charge level above limit");
	volt_low_a: assert property (
		reg_rvalid && $past(reg_addr) == 8'h23 |-> reg_rdata[2:0] == 3'h0)
		else $error("voltage low unused bits set");

	// main scenarios seen
	cover property (reg_wr && reg_addr == 8'h25 && reg_wdata[7]);
	cover property (meas_upd && meas_level > 7'h64);
	cover property (reg_rd && reg_addr == 8'h22 ##[1:12]
		reg_rd && reg_addr == 8'h23);
endmodule : fgp_regs_sva

bind fgp_regs fgp_regs_sva fgp_regs_sva_i (.clock, .nrst, .reg_addr,
	.reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .meas_upd,
	.meas_level, .meas_volt, .thermistor_input, .resistance_points,
	.low_charge_resistance_ratio, .charging_resistance_coeff,
	.temperature_source_select, .host_temperature_value,
	.battery_temperature);

`default_nettype wire

// ---- dv/fgp_regs_bench.sv ----
/*
 * Self-checking bench for the fuel gauge parameter bank.
 * Assumes: host model drives the register port; bench plays gauge core.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	$display("wrong value at %0t got %h exp %h", $time, got, exp); \
	fails++; end end

module fgp_regs_bench;
	import fgp_pkg::*;
	logic		clock, nrst, reg_wr, reg_rd, reg_rvalid, meas_upd;
	logic		temperature_source_select;
	logic [7:0]	reg_addr, reg_wdata, reg_rdata, rd_d, vh;
	logic [3:0]	charging_resistance_coeff;
	fgp_level_t	meas_level;
	fgp_volt_t	meas_volt;
	fgp_temp_t	thermistor_input, host_temperature_value, battery_temperature;
	fgp_res_arr_t	resistance_points;
	fgp_ratio_t	low_charge_resistance_ratio;
	int		fails = 0, comparisons = 0, i;
	// address, reset value, data written, value read back
	logic [31:0]	rows [12] = '{32'h1A3F1010, 32'h1B3FFFFF, 32'h1C3F0000,
		32'h1D3FA5A5, 32'h1E3F5A5A, 32'h1F08FF3F, 32'h201BFF7F, 32'h2100AA00,
		32'h2200FF00, 32'h23000F00, 32'h25000100, 32'h3000FF00};

	// ****************************************************************
	// instances and helpers
	// ****************************************************************
	fgp_regs fgp_regs_i (.clock, .nrst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata, .reg_rvalid, .meas_upd, .meas_level, .meas_volt,
		.thermistor_input, .resistance_points, .low_charge_resistance_ratio,
		.charging_resistance_coeff, .temperature_source_select,
		.host_temperature_value, .battery_temperature);
	fgp_host_model fgp_host_model_i (.clock, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata, .reg_rvalid);

	always #4 clock = ~clock;

	task automatic test_done;
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// a lost answer ends the run at once
	task automatic get(input logic [7:0] a, input logic [7:0] e);
		logic ok;
		fgp_host_model_i.rd(a, rd_d, ok);
		if (ok !== 1'b1) begin
			fails++;
			test_done();
		end else
			`CHK(rd_d, e)
	endtask : get

	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick

	// gauge core result strobe, lines flipped when idle
	task automatic meas(input fgp_level_t l, input fgp_volt_t v);
		tick();
		meas_upd = 1'b1;
		meas_level = l;
		meas_volt = v;
		tick();
		meas_upd = 1'b0;
		meas_level = ~l;
		meas_volt = ~v;
	endtask : meas

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		meas_upd = 1'b0;
		meas_level = 7'h00;
		meas_volt = 13'h0000;
		thermistor_input = 6'h15;
		repeat (4) @(posedge clock);
		#1;
		nrst = 1'b1;
		`CHK(resistance_points, {5{8'h3F}})
		`CHK(low_charge_resistance_ratio, FGP_RATIO_X1)
		`CHK(charging_resistance_coeff, 4'h8)
		`CHK(temperature_source_select, 1'b0)
		`CHK(host_temperature_value, 6'h1B)
		for (i = 0; i < 12; i++) begin
			get(rows[i][31:24], rows[i][23:16]);
			fgp_host_model_i.wr(rows[i][31:24], rows[i][15:8]);
			get(rows[i][31:24], rows[i][7:0]);
		end
		`CHK(resistance_points, {8'h5A, 8'hA5, 8'h00, 8'hFF, 8'h10})
		for (i = 0; i < 4; i++) begin
			fgp_host_model_i.wr(8'h1F, 8'(i * 16 + 3));
			`CHK(low_charge_resistance_ratio, fgp_ratio_t'(i))
			`CHK(charging_resistance_coeff, 4'h3)
		end
		// temperature source both ways
		fgp_host_model_i.wr(8'h20, 8'h00);
		repeat (2) tick();
		`CHK(battery_temperature, 6'h15)
		thermistor_input = 6'h2A;
		repeat (2) tick();
		`CHK(battery_temperature, 6'h2A)
		fgp_host_model_i.wr(8'h20, 8'h5F);
		repeat (2) tick();
		`CHK(battery_temperature, 6'h1F)
		`CHK(temperature_source_select, 1'b1)
		`CHK(host_temperature_value, 6'h1F)
		// clamped level, split voltage, snapshot across a new result
		meas(7'h7F, 13'h1ABC);
		get(8'h21, 8'h64);
		get(8'h22, 8'hD5);
		vh = rd_d;
		meas(7'h32, 13'h0005);
		get(8'h23, 8'hE0);
		`CHK(13'(vh * 32 + rd_d / 8), 13'h1ABC)
		get(8'h23, 8'h28);
		fgp_host_model_i.wr(8'h21, 8'h11);
		get(8'h21, 8'h32);
		// clear needs bit 7 set
		fgp_host_model_i.wr(8'h25, 8'h7F);
		get(8'h21, 8'h32);
		fgp_host_model_i.wr(8'h25, 8'h80);
		get(8'h21, 8'h00);
		get(8'h22, 8'h00);
		get(8'h23, 8'h00);
		// second reset in mid-run
		nrst = 1'b0;
		repeat (2) tick();
		nrst = 1'b1;
		`CHK(resistance_points, {5{8'h3F}})
		`CHK(charging_resistance_coeff, 4'h8)
		`CHK(temperature_source_select, 1'b0)
		`CHK(host_temperature_value, 6'h1B)
		get(8'h1A, 8'h3F);
		get(8'h1F, 8'h08);
		get(8'h20, 8'h1B);
		test_done();
	end
endmodule : fgp_regs_bench

`default_nettype wire
